// ===== rail1_slope_blank_cfg_bank.sv
// rail 1 slope, blanking and fence offset register bank with its decode
// Overview of operation
// - fences 1-4 offsets, signed nibbles, low register
// - fences 5-8 offsets, signed nibbles, high register
// - phase count picks one of three timing sets
// - thresholds from top nibbles of blanking 1,2
// - blanking is 20ns plus field times 5ns
// - chosen set bits 5:0 give blanking
// - blanking 3 top nibble ignored, reads zero
// - slope setup bits 15:12 are output trim
// - multiplier 1.2 to 1.5 scales slope count
// - slope setup bits 9:0 clamp time
// - peak setup bits 15:9 initial source
// - select codes: sets 0-3, auto, invalid
// - peak setup bits 4:0 peak level
// - zone widths chain into fence boundaries
`timescale 1ns/1ps
module rail1_slope_blank_cfg_bank #(
  parameter int SENSE_W = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // management command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_page,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic rsp_err,
  // operating point from the phase controller
  input wire logic [4:0] phase_count,
  input wire logic [15:0] switch_period_ns,
  // selected timing
  output slope_blank_pkg::timing_set_s sel_timing,
  output logic [8:0] blank_time_ns,
  output logic [15:0] slope_count,
  // slope setup
  output slope_blank_pkg::slope_cfg_s slope_cfg,
  output slope_blank_pkg::slope_select_s slope_select,
  // per-phase current sense path
  input wire logic sense_valid,
  input wire logic [3:0] sense_phase,
  input wire logic signed [SENSE_W-1:0] sense_value,
  output logic bal_valid,
  output logic signed [SENSE_W:0] bal_value
);

  // sized copies of package arithmetic constants
  localparam logic [15:0] STEP_NS_W = 16'(slope_blank_pkg::STEP_NS);
  localparam logic [4:0] COEF_BASE_W = 5'(slope_blank_pkg::COEF_BASE);
  localparam logic [20:0] COEF_DIV_W = 21'(slope_blank_pkg::COEF_DIV);
  localparam logic [8:0] BLANK_FIXED_W = 9'(slope_blank_pkg::BLANK_FIXED_NS);
  localparam logic [8:0] STEP_NS_B = 9'(slope_blank_pkg::STEP_NS);

  // fence index (1..8) of a 1-based phase, 0 when beyond fence 8
  // the chain runs all eight fences so the loop has a fixed trip count
  function automatic logic [3:0] fence_of(input logic [15:0] zone, input logic [4:0] phase1);
    logic [5:0] bound;
    logic [3:0] idx;
    bound = 6'h00;
    idx = 4'h0;
    for (int k = 0; k < 8; k++) begin
      // each zone widens the fence by its width plus one
      bound = bound + {4'h0, zone[2*k +: 2]} + 6'h01;
      if (idx == 4'h0 && {1'b0, phase1} <= bound) begin
        idx = 4'(k + 1);
      end
    end
    return idx;
  endfunction

  // slope count: period over phases, less reset, times 1.2..1.5
  // limitation: the result is cut to 16 bits, so period per phase stays below 43690 ns
  function automatic logic [15:0] scale_count(input logic [15:0] period, input logic [4:0] phases,
                                              input logic [5:0] reset_time, input logic [1:0] coef);
    logic [15:0] per;
    logic [15:0] reset_ns;
    logic [15:0] base;
    logic [20:0] prod;
    per = (phases == 5'h00) ? 16'h0000 : 16'(period / phases);
    reset_ns = 16'(reset_time * STEP_NS_W);
    base = (per > reset_ns) ? 16'(per - reset_ns) : 16'h0000;
    prod = 21'(base * (COEF_BASE_W + {3'h0, coef}));
    return 16'(prod / COEF_DIV_W);
  endfunction

  // register storage, one word per command code
  logic [15:0] bank_reg [slope_blank_pkg::REG_COUNT];
  // answer flops
  logic rsp_valid_reg;
  logic [15:0] rsp_rdata_reg;
  logic rsp_err_reg;
  // derived outputs
  slope_blank_pkg::timing_set_s sel_timing_reg;
  logic [8:0] blank_ns_reg;
  logic [15:0] slope_count_reg;
  slope_blank_pkg::slope_select_s select_reg;
  logic bal_valid_reg;
  logic signed [SENSE_W:0] bal_value_reg;

  // command decode
  // idx only means something while hit is high; codes past the bank never store
  wire page_ok = (cmd_page == slope_blank_pkg::PAGE_RAIL1);
  wire code_ok = (cmd_code >= slope_blank_pkg::ADDR_ZONE) && (cmd_code <= slope_blank_pkg::ADDR_LIGHT);
  wire hit = page_ok && code_ok;
  wire [3:0] idx = 4'(cmd_code - slope_blank_pkg::REG_BASE);
  wire do_write = cmd_valid && cmd_write && hit;
  // the reserved top nibble of blanking 3 never stores
  wire [15:0] wr_mask = (idx == slope_blank_pkg::IDX_BLANK3) ? slope_blank_pkg::BLANK3_MASK : 16'hffff;
  wire [15:0] wr_data = cmd_wdata & wr_mask;
  // unmapped reads answer zero so stale storage never leaks out
  wire [15:0] rd_data = hit ? bank_reg[idx] : 16'h0000;

  // named register words
  wire [15:0] zone_w = bank_reg[slope_blank_pkg::IDX_ZONE];
  wire [15:0] ofs_lo_w = bank_reg[slope_blank_pkg::IDX_OFS_LO];
  wire [15:0] ofs_hi_w = bank_reg[slope_blank_pkg::IDX_OFS_HI];
  wire [15:0] blank1_w = bank_reg[slope_blank_pkg::IDX_BLANK1];
  wire [15:0] blank2_w = bank_reg[slope_blank_pkg::IDX_BLANK2];
  wire [15:0] blank3_w = bank_reg[slope_blank_pkg::IDX_BLANK3];
  wire [15:0] slope_w = bank_reg[slope_blank_pkg::IDX_SLOPE];
  wire [15:0] peak_w = bank_reg[slope_blank_pkg::IDX_PEAK];

  // thresholds sit in the top nibble of blanking 1 and 2
  wire [3:0] phase_threshold_one = blank1_w[slope_blank_pkg::THR_LSB +: 4];
  wire [3:0] phase_threshold_two = blank2_w[slope_blank_pkg::THR_LSB +: 4];

  // the three candidate timing sets
  // set 3 has no threshold of its own: it covers every count below both thresholds
  wire slope_blank_pkg::timing_set_s set_one_w = {blank1_w[slope_blank_pkg::RESET_LSB +: 6],
                                                   blank1_w[slope_blank_pkg::BLANK_LSB +: 6]};
  wire slope_blank_pkg::timing_set_s set_two_w = {blank2_w[slope_blank_pkg::RESET_LSB +: 6],
                                                   blank2_w[slope_blank_pkg::BLANK_LSB +: 6]};
  wire slope_blank_pkg::timing_set_s set_three_w = {blank3_w[slope_blank_pkg::RESET_LSB +: 6],
                                                     blank3_w[slope_blank_pkg::BLANK_LSB +: 6]};

  // set 1 wins at or above threshold 1, then set 2, else set 3
  wire at_one = phase_count >= {1'b0, phase_threshold_one};
  wire at_two = phase_count >= {1'b0, phase_threshold_two};
  wire slope_blank_pkg::timing_set_s sel_next = at_one ? set_one_w : (at_two ? set_two_w : set_three_w);

  // fixed 20ns plus 5ns per count of the chosen blanking field
  wire [8:0] blank_ns_next = BLANK_FIXED_W + 9'(sel_next.blank_time * STEP_NS_B);

  // multiplier code scales the period-per-phase less reset
  wire [1:0] coef_w = slope_w[slope_blank_pkg::COEF_LSB +: 2];
  wire [15:0] slope_count_next = scale_count(switch_period_ns, phase_count, sel_next.reset_time, coef_w);

  // parameter select decode
  // invalid codes still read back as written; only the decode flags them
  wire [3:0] sel_code = peak_w[slope_blank_pkg::SEL_LSB +: 4];
  wire sel_auto = (sel_code == slope_blank_pkg::SEL_AUTO_A) || (sel_code == slope_blank_pkg::SEL_AUTO_B);
  wire sel_set = sel_code <= slope_blank_pkg::SEL_SET_MAX;
  wire slope_blank_pkg::slope_select_s select_next = {sel_set ? sel_code[1:0] : 2'b00, sel_auto,
                                                       !sel_set && !sel_auto};

  // fence lookup for the sensed phase
  // sense_phase counts from zero while the fence chain counts from one
  wire [4:0] phase1 = {1'b0, sense_phase} + 5'h01;
  wire [3:0] fence_idx = fence_of(zone_w, phase1);
  // fences 1-4 low word, 5-8 high word, each a signed nibble
  wire [31:0] all_offsets = {ofs_hi_w, ofs_lo_w};
  wire [4:0] nib_lsb = {3'(fence_idx - 4'h1), 2'b00};
  wire signed [3:0] fence_offset = (fence_idx == 4'h0) ? 4'sh0 : $signed(all_offsets[nib_lsb +: 4]);
  // sign-extended sum, one bit wider so it never wraps
  // offset nibble is sign-extended before the add, so a negative offset lowers the sum
  wire signed [SENSE_W:0] bal_next = $signed({sense_value[SENSE_W-1], sense_value})
                                     + $signed({{(SENSE_W-3){fence_offset[3]}}, fence_offset});

  // register bank writes; reset puts every word to its default
  // the reset branch loads constants only, never data from the port
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < slope_blank_pkg::REG_COUNT; i++) begin
        bank_reg[i] <= slope_blank_pkg::RST_VAL;
      end
    end else if (do_write) begin
      // masked data so reserved bits stay zero
      bank_reg[idx] <= wr_data;
    end
  end

  // one-cycle answer to every command; unmapped codes flag an error
  // every command is answered so the host never waits on a missing strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_reg <= 1'b0;
      rsp_rdata_reg <= 16'h0000;
      rsp_err_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= cmd_valid;
      // writes answer with zero data, reads with the word
      rsp_rdata_reg <= (cmd_valid && !cmd_write) ? rd_data : 16'h0000;
      rsp_err_reg <= cmd_valid && !hit;
    end
  end

  // timing selection registered so outputs are glitch-free
  // limitation: one cycle of lag after phase_count changes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_timing_reg <= '0;
      blank_ns_reg <= 9'h000;
      slope_count_reg <= 16'h0000;
      select_reg <= '0;
    end else begin
      sel_timing_reg <= sel_next;
      blank_ns_reg <= blank_ns_next;
      slope_count_reg <= slope_count_next;
      select_reg <= select_next;
    end
  end

  // balanced current path, one cycle of latency
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bal_valid_reg <= 1'b0;
      bal_value_reg <= '0;
    end else begin
      bal_valid_reg <= sense_valid;
      // value holds between samples
      if (sense_valid) begin
        bal_value_reg <= bal_next;
      end
    end
  end

  // outputs straight from flops
  assign rsp_valid = rsp_valid_reg;
  assign rsp_rdata = rsp_rdata_reg;
  assign rsp_err = rsp_err_reg;
  assign sel_timing = sel_timing_reg;
  assign blank_time_ns = blank_ns_reg;
  assign slope_count = slope_count_reg;
  assign slope_select = select_reg;
  assign bal_valid = bal_valid_reg;
  assign bal_value = bal_value_reg;
  // plain setup fields taken straight from the bank words
  // trade-off: setup fields skip a second flop since they already come from bank flops
  assign slope_cfg.four_phase_output_trim = slope_w[slope_blank_pkg::TRIM4_LSB +: 4];
  assign slope_cfg.slope_count_multiplier = coef_w;
  assign slope_cfg.slope_clamp_interval = slope_w[slope_blank_pkg::CLAMP_LSB +: 10];
  assign slope_cfg.slope_initial_source = peak_w[slope_blank_pkg::INIT_LSB +: 7];
  assign slope_cfg.slope_peak_level = peak_w[slope_blank_pkg::PEAK_LSB +: 5];
  // trim words are passed on as written; software keeps the low phase trim zero
  assign slope_cfg.low_phase_trim = bank_reg[slope_blank_pkg::IDX_TRIM];
  assign slope_cfg.light_load_trim = bank_reg[slope_blank_pkg::IDX_LIGHT];

  // checks on the bank behaviour
  // properties sample before the edge, so derived outputs lag the bank by one cycle
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // reserved nibble of blanking 3 reads zero after any write
  AST_BLANK3_TOP_ZERO: assert property (
    cmd_valid && !cmd_write && page_ok && cmd_code == slope_blank_pkg::ADDR_BLANK3
    |=> rsp_rdata[15:12] == 4'h0)
    else $error("blanking 3 reserved bits read nonzero");

  // high offset word captures written data
  AST_OFS_HI_WRITE: assert property (
    cmd_valid && cmd_write && page_ok && cmd_code == slope_blank_pkg::ADDR_OFS_HI
    |=> ofs_hi_w == $past(cmd_wdata))
    else $error("high offset write lost");

  // at or above threshold 1 the first set drives
  AST_SET_ONE: assert property (
    phase_count >= {1'b0, blank1_w[15:12]} |=> sel_timing == $past(set_one_w))
    else $error("set 1 not selected");

  // between thresholds the second set drives
  AST_SET_TWO: assert property (
    phase_count < {1'b0, blank1_w[15:12]} && phase_count >= {1'b0, blank2_w[15:12]}
    |=> sel_timing == $past(set_two_w))
    else $error("set 2 not selected");

  // below both thresholds the third set drives
  AST_SET_THREE: assert property (
    phase_count < {1'b0, blank1_w[15:12]} && phase_count < {1'b0, blank2_w[15:12]}
    |=> sel_timing == $past(set_three_w))
    else $error("set 3 not selected");

  // blanking ns tracks the selected field
  // the first edge after release is skipped: both flops still hold their reset zeros
  AST_BLANK_NS: assert property (
    $past(rst_n) |-> blank_time_ns == 9'h014 + 9'h005 * {3'h0, sel_timing.blank_time})
    else $error("blanking time formula wrong");

  // auto codes give auto slope, never invalid
  AST_AUTO_SLOPE: assert property (
    peak_w[8:5] >= 4'he |=> slope_select.auto_slope && !slope_select.invalid)
    else $error("auto slope code misdecoded");

  // codes 4 to 13 are invalid
  AST_SEL_INVALID: assert property (
    peak_w[8:5] > 4'h3 && peak_w[8:5] < 4'he |=> slope_select.invalid && !slope_select.auto_slope)
    else $error("invalid select not flagged");

  // phase 1 always belongs to fence 1
  AST_PHASE_ONE: assert property (
    sense_valid && sense_phase == 4'h0
    |=> bal_valid && bal_value == $past(sense_value) + $signed($past(ofs_lo_w[3:0])))
    else $error("phase 1 offset not applied");

  // unmapped codes answer with an error next cycle
  AST_UNMAPPED: assert property (
    cmd_valid && !code_ok |=> rsp_valid && rsp_err && rsp_rdata == 16'h0000)
    else $error("unmapped code not refused");

  // every command is answered on the next edge
  AST_ANSWER_STROBE: assert property (
    cmd_valid |=> rsp_valid)
    else $error("command left without an answer");

  // no command, no answer, and the answer lines fall back to zero
  AST_QUIET_ANSWER: assert property (
    !cmd_valid |=> !rsp_valid && !rsp_err && rsp_rdata == 16'h0000)
    else $error("answer strobe without a command");

  // each sensed sample gives one balanced strobe a cycle later
  AST_BAL_STROBE: assert property (
    sense_valid |=> bal_valid)
    else $error("balanced sample strobe missing");

  // a refused write leaves the bank untouched
  AST_REFUSED_NO_STORE: assert property (
    cmd_valid && cmd_write && !hit |=> blank1_w == $past(blank1_w) && zone_w == $past(zone_w))
    else $error("refused write changed the bank");

  // main scenarios
  COV_SET_TWO: cover property (!at_one && at_two ##1 sel_timing == $past(set_two_w));
  COV_AUTO: cover property (slope_select.auto_slope);
  COV_LAST_PHASE: cover property (sense_valid && sense_phase == 4'hf ##1 bal_valid);
  COV_READ: cover property (cmd_valid && !cmd_write && hit ##1 rsp_valid && !rsp_err);
  COV_REFUSED: cover property (cmd_valid && !hit ##1 rsp_err);

endmodule

// ===== rail1_slope_blank_cfg_bank_tb.sv
// self-checking bench for the rail 1 slope, blanking and fence offset bank
`timescale 1ns/1ps
module rail1_slope_blank_cfg_bank_tb;
  // clock, reset and command port
  logic sys_clk;
  logic rst_n;
  logic cmd_valid;
  logic cmd_write;
  logic [7:0] cmd_page;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata;
  logic rsp_valid;
  logic [15:0] rsp_rdata;
  logic rsp_err;
  // operating point and selected timing
  logic [4:0] phase_count;
  logic [15:0] switch_period_ns;
  slope_blank_pkg::timing_set_s sel_timing;
  logic [8:0] blank_time_ns;
  logic [15:0] slope_count;
  slope_blank_pkg::slope_cfg_s slope_cfg;
  slope_blank_pkg::slope_select_s slope_select;
  // sense path
  logic sense_valid;
  logic [3:0] sense_phase;
  logic signed [11:0] sense_value;
  logic bal_valid;
  logic signed [12:0] bal_value;
  // bookkeeping; shadow copy of the bank indexed by code minus base
  int fail_count;
  int comparisons;
  logic [15:0] shadow [10];

  rail1_slope_blank_cfg_bank u_rail1_slope_blank_cfg_bank (
    .sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_page(cmd_page), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .phase_count(phase_count),
    .switch_period_ns(switch_period_ns), .sel_timing(sel_timing), .blank_time_ns(blank_time_ns),
    .slope_count(slope_count), .slope_cfg(slope_cfg), .slope_select(slope_select),
    .sense_valid(sense_valid), .sense_phase(sense_phase), .sense_value(sense_value),
    .bal_valid(bal_valid), .bal_value(bal_value)
  );

  // free-running 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // one compare; four-state so an unknown never matches
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  // one command: strobe for one edge, answer is sampled in the cycle it stands
  task automatic cmd(input logic wr, input logic [7:0] pg, input logic [7:0] code, input logic [15:0] d,
                     input logic err_exp, input logic [15:0] rd_exp);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_page <= pg;
    cmd_code <= code;
    cmd_wdata <= d;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    #1;
    chk(rsp_valid, 1'b1);
    chk(rsp_err, err_exp);
    chk(rsp_rdata, rd_exp);
  endtask

  // software side: reset time kept within blanking, low phase trim kept at zero
  function automatic logic [15:0] legal(input logic [7:0] code, input logic [15:0] d);
    if (code == slope_blank_pkg::ADDR_TRIM) return 16'h0000;
    if (code >= slope_blank_pkg::ADDR_BLANK1 && code <= slope_blank_pkg::ADDR_BLANK3 && d[11:6] > d[5:0])
      return {d[15:12], d[5:0], d[5:0]};
    return d;
  endfunction

  // write on page 0 and keep the shadow in step; top nibble of set three never stores
  task automatic wr(input logic [7:0] code, input logic [15:0] d_raw);
    logic [15:0] d;
    d = legal(code, d_raw);
    cmd(1'b1, slope_blank_pkg::PAGE_RAIL1, code, d, 1'b0, 16'h0000);
    shadow[code - slope_blank_pkg::REG_BASE] = (code == slope_blank_pkg::ADDR_BLANK3) ? (d & 16'h0fff) : d;
  endtask

  // read on page 0 against the shadow
  task automatic rd(input logic [7:0] code);
    cmd(1'b0, slope_blank_pkg::PAGE_RAIL1, code, 16'h0000, 1'b0, shadow[code - slope_blank_pkg::REG_BASE]);
  endtask

  // timing set chosen by phase count against the two thresholds
  function automatic logic [11:0] exp_set(input logic [4:0] pc);
    if (pc >= {1'b0, shadow[3][15:12]}) return shadow[3][11:0];
    if (pc >= {1'b0, shadow[4][15:12]}) return shadow[4][11:0];
    return shadow[5][11:0];
  endfunction

  // slope count: period per phase less reset time, floored, then scaled by 1.2 to 1.5
  function automatic logic [15:0] exp_cnt(input logic [4:0] pc, input logic [15:0] per);
    logic [11:0] s;
    int base;
    s = exp_set(pc);
    if (pc == 5'h00) return 16'h0000;
    base = int'(per / pc) - 5 * int'(s[11:6]);
    if (base < 0) base = 0;
    return 16'(base * (12 + int'(shadow[6][11:10])) / 10);
  endfunction

  // select decode: sets 0-3, two auto codes, rest flagged invalid
  function automatic logic [3:0] exp_selc(input logic [3:0] c);
    if (c <= 4'h3) return {c[1:0], 2'b00};
    if (c >= 4'he) return 4'b0010;
    return 4'b0001;
  endfunction

  // walk the zone chain; phases past the last fence get no offset
  function automatic logic signed [12:0] exp_bal(input logic [3:0] ph, input logic [11:0] v);
    int fence;
    logic found;
    logic [3:0] ofs;
    fence = 0;
    found = 1'b0;
    ofs = 4'h0;
    for (int k = 0; k < 8; k++) begin
      fence = fence + int'(shadow[0][2*k +: 2]) + 1;
      if (!found && int'(ph) + 1 <= fence) begin
        found = 1'b1;
        ofs = (k < 4) ? shadow[1][4*k +: 4] : shadow[2][4*(k-4) +: 4];
      end
    end
    return $signed({v[11], v}) + $signed({{9{ofs[3]}}, ofs});
  endfunction

  // set an operating point, let two edges pass, then check the selection outputs
  task automatic check_sel(input logic [4:0] pc, input logic [15:0] per);
    logic [11:0] s;
    @(posedge sys_clk);
    phase_count <= pc;
    switch_period_ns <= per;
    repeat (2) @(posedge sys_clk);
    #1;
    s = exp_set(pc);
    chk(sel_timing, s);
    chk(blank_time_ns, 20 + 5 * s[5:0]);
    chk(slope_count, exp_cnt(pc, per));
    chk(slope_cfg, {shadow[6], shadow[7][15:9], shadow[7][4:0], shadow[8], shadow[9]});
  endtask

  // one sensed sample through the balance path
  task automatic sense(input logic [3:0] ph, input logic [11:0] v);
    @(posedge sys_clk);
    sense_valid <= 1'b1;
    sense_phase <= ph;
    sense_value <= v;
    @(posedge sys_clk);
    sense_valid <= 1'b0;
    #1;
    chk(bal_valid, 1'b1);
    chk(bal_value, exp_bal(ph, v));
  endtask

  // counts, verdict and end of run
  task automatic final_report;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    int unsigned seed;
    {cmd_valid, cmd_write, cmd_page, cmd_code, cmd_wdata} = '0;
    {phase_count, switch_period_ns, sense_valid, sense_phase, sense_value} = '0;
    rst_n = 1'b0;
    fail_count = 0;
    comparisons = 0;
    foreach (shadow[i]) shadow[i] = 16'h0000;
    seed = $urandom(32'h5616);
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values, then random write and readback of every register
    for (int i = 0; i < 10; i++) rd(slope_blank_pkg::REG_BASE + 8'(i));
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 10; i++) begin
        wr(slope_blank_pkg::REG_BASE + 8'(i), 16'($urandom));
        rd(slope_blank_pkg::REG_BASE + 8'(i));
      end
    end
    wr(slope_blank_pkg::ADDR_BLANK3, 16'hffff);
    rd(slope_blank_pkg::ADDR_BLANK3);
    // refused: other page, codes just outside the bank; nothing may store
    cmd(1'b1, 8'h01, slope_blank_pkg::ADDR_BLANK1, 16'h5a5a, 1'b1, 16'h0000);
    cmd(1'b1, 8'h00, 8'hc2, 16'h5a5a, 1'b1, 16'h0000);
    cmd(1'b0, 8'h00, 8'hb7, 16'h0000, 1'b1, 16'h0000);
    rd(slope_blank_pkg::ADDR_BLANK1);
    // thresholds 8 and 3; sweep phase counts 0 to 16 across both boundaries
    wr(slope_blank_pkg::ADDR_BLANK1, {4'h8, 12'($urandom)});
    wr(slope_blank_pkg::ADDR_BLANK2, {4'h3, 12'($urandom)});
    wr(slope_blank_pkg::ADDR_BLANK3, 16'($urandom));
    for (int pc = 0; pc <= 16; pc++) check_sel(5'(pc), 16'($urandom_range(40000, 256)));
    // every multiplier code, also with a period short enough to floor at zero
    for (int c = 0; c < 4; c++) begin
      wr(slope_blank_pkg::ADDR_SLOPE, {4'($urandom), 2'(c), 10'($urandom)});
      check_sel(5'($urandom_range(16, 1)), 16'($urandom_range(40000, 256)));
      check_sel(5'd16, 16'd64);
    end
    // every select code
    for (int c = 0; c < 16; c++) begin
      wr(slope_blank_pkg::ADDR_PEAK, {7'($urandom), 4'(c), 5'($urandom)});
      repeat (2) @(posedge sys_clk);
      #1;
      chk(slope_select, exp_selc(4'(c)));
    end
    // zone partitions: narrowest, widest, then random; every phase sensed
    for (int r = 0; r < 4; r++) begin
      wr(slope_blank_pkg::ADDR_ZONE, (r == 0) ? 16'h0000 : (r == 1) ? 16'hffff : 16'($urandom));
      wr(slope_blank_pkg::ADDR_OFS_LO, 16'($urandom));
      wr(slope_blank_pkg::ADDR_OFS_HI, (r == 0) ? 16'h8787 : 16'($urandom));
      for (int ph = 0; ph < 16; ph++) sense(4'(ph), 12'($urandom));
    end
    // reset in mid-run clears the bank
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (shadow[i]) shadow[i] = 16'h0000;
    rd(slope_blank_pkg::ADDR_PEAK);
    check_sel(5'd4, 16'd1000);
    final_report();
  end
endmodule

// ===== slope_blank_pkg.sv
// constants, field layout and carriers for the rail 1 slope and blanking bank
package slope_blank_pkg;
  // command codes on management page 0
  localparam logic [7:0] PAGE_RAIL1 = 8'h00;
  localparam logic [7:0] REG_BASE = 8'hb8;
  localparam logic [7:0] ADDR_ZONE = 8'hb8;
  localparam logic [7:0] ADDR_OFS_LO = 8'hb9;
  localparam logic [7:0] ADDR_OFS_HI = 8'hba;
  localparam logic [7:0] ADDR_BLANK1 = 8'hbb;
  localparam logic [7:0] ADDR_BLANK2 = 8'hbc;
  localparam logic [7:0] ADDR_BLANK3 = 8'hbd;
  localparam logic [7:0] ADDR_SLOPE = 8'hbe;
  localparam logic [7:0] ADDR_PEAK = 8'hbf;
  localparam logic [7:0] ADDR_TRIM = 8'hc0;
  localparam logic [7:0] ADDR_LIGHT = 8'hc1;
  localparam int REG_COUNT = 10;
  // bank indices
  localparam logic [3:0] IDX_ZONE = 4'(ADDR_ZONE - REG_BASE);
  localparam logic [3:0] IDX_OFS_LO = 4'(ADDR_OFS_LO - REG_BASE);
  localparam logic [3:0] IDX_OFS_HI = 4'(ADDR_OFS_HI - REG_BASE);
  localparam logic [3:0] IDX_BLANK1 = 4'(ADDR_BLANK1 - REG_BASE);
  localparam logic [3:0] IDX_BLANK2 = 4'(ADDR_BLANK2 - REG_BASE);
  localparam logic [3:0] IDX_BLANK3 = 4'(ADDR_BLANK3 - REG_BASE);
  localparam logic [3:0] IDX_SLOPE = 4'(ADDR_SLOPE - REG_BASE);
  localparam logic [3:0] IDX_PEAK = 4'(ADDR_PEAK - REG_BASE);
  localparam logic [3:0] IDX_TRIM = 4'(ADDR_TRIM - REG_BASE);
  localparam logic [3:0] IDX_LIGHT = 4'(ADDR_LIGHT - REG_BASE);
  // reset value and the writable mask of the third blanking set
  localparam logic [15:0] RST_VAL = 16'h0000;
  localparam logic [15:0] BLANK3_MASK = 16'h0fff;
  // field positions
  localparam int THR_LSB = 12;
  localparam int RESET_LSB = 6;
  localparam int BLANK_LSB = 0;
  localparam int TRIM4_LSB = 12;
  localparam int COEF_LSB = 10;
  localparam int CLAMP_LSB = 0;
  localparam int INIT_LSB = 9;
  localparam int SEL_LSB = 5;
  localparam int PEAK_LSB = 0;
  // timing arithmetic, ns
  localparam int BLANK_FIXED_NS = 20;
  localparam int STEP_NS = 5;
  localparam int COEF_BASE = 12;
  localparam int COEF_DIV = 10;
  // slope parameter select codes
  localparam logic [3:0] SEL_SET_MAX = 4'h3;
  localparam logic [3:0] SEL_AUTO_A = 4'he;
  localparam logic [3:0] SEL_AUTO_B = 4'hf;
  // one set of slope-reset and blanking counts
  typedef struct packed {
    logic [5:0] reset_time;
    logic [5:0] blank_time;
  } timing_set_s;
  // plain slope setup fields
  typedef struct packed {
    logic [3:0] four_phase_output_trim;
    logic [1:0] slope_count_multiplier;
    logic [9:0] slope_clamp_interval;
    logic [6:0] slope_initial_source;
    logic [4:0] slope_peak_level;
    logic [15:0] low_phase_trim;
    logic [15:0] light_load_trim;
  } slope_cfg_s;
  // decoded slope parameter select
  typedef struct packed {
    logic [1:0] param_set;
    logic auto_slope;
    logic invalid;
  } slope_select_s;
endpackage
